// [hw/pcrb_regs.svh]
// constants of the pll configuration register bank: offsets, fields, resets
// assumes inclusion by bare name from the package and the design modules
`ifndef PCRB_REGS_SVH
`define PCRB_REGS_SVH

// ============================================================
// register file geometry
`define PCRB_NUM_CFG_REGS 38
`define PCRB_ADDR_SPAN 40
`define PCRB_LAST_INDEX 8'h27
`define PCRB_IMPL_MASK 40'hFFFEC30000
`define PCRB_RESET_VALUE 8'h00

// ============================================================
// register offsets
`define PCRB_OFS_LOAD_CAP_A 8'h10
`define PCRB_OFS_LOAD_CAP_B 8'h11
`define PCRB_OFS_OUTPUT_DIVIDE_VALUE_HI 8'h16
`define PCRB_OFS_OUTPUT_DIVIDE_VALUE_LO 8'h17
`define PCRB_OFS_FB_DIV_0 8'h19
`define PCRB_OFS_FB_DIV_1 8'h1A
`define PCRB_OFS_FB_DIV_2 8'h1B
`define PCRB_OFS_FB_DIV_3 8'h1C
`define PCRB_OFS_FB_DIV_4 8'h1D
`define PCRB_OFS_FB_DIV_5 8'h1E
`define PCRB_OFS_FB_DIV_6 8'h1F
`define PCRB_OFS_FB_DIV_7 8'h20
`define PCRB_OFS_MOD_DITHER 8'h21
`define PCRB_OFS_DOUBLER_PUMP 8'h22
`define PCRB_OFS_PHASE_FILTER 8'h23
`define PCRB_OFS_LF_R2 8'h24
`define PCRB_OFS_LF_C1 8'h25
`define PCRB_OFS_LF_R3 8'h26
`define PCRB_OFS_LF_C3 8'h27
`define PCRB_OFS_VCO_CAL 8'h48

// ============================================================
// field positions and limits
`define PCRB_VCO_CAL_BIT 1
`define PCRB_DOUBLER_BIT 5
`define PCRB_FILTER_EN_BIT 2
`define PCRB_INT_W 12
`define PCRB_FRAC_W 22
`define PCRB_OUTPUT_DIVIDE_VALUE_W 9
`define PCRB_INT_MIN 12'h001
`define PCRB_DEN_MIN 22'h000001
`define PCRB_OUTPUT_DIVIDE_VALUE_MIN 9'h005
`define PCRB_FACTOR_OFF 2'h1
`define PCRB_FACTOR_ON 2'h2
`define PCRB_PFD_MHZ_OFF 8'h32
`define PCRB_PFD_MHZ_ON 8'h64

`endif

// [hw/pcrb_pkg.sv]
// types shared by the pll configuration register bank modules
// assumes pcrb_regs.svh is on the include path
`include "pcrb_regs.svh"

package pcrb_pkg;

  // ============================================================
  // decoded pll configuration
  typedef struct packed {
    logic [7:0] load_cap_a;
    logic [7:0] load_cap_b;
    logic [`PCRB_INT_W-1:0] fb_int;
    logic [`PCRB_FRAC_W-1:0] fb_num;
    logic [`PCRB_FRAC_W-1:0] feedback_denominator;
    logic [`PCRB_OUTPUT_DIVIDE_VALUE_W-1:0] output_divide_value;
    logic [1:0] dsm_order;
    logic [1:0] dither;
    logic doubler_en;
    logic [3:0] pump_sel;
    logic [2:0] phase_shift;
    logic filter_en;
    logic [7:0] lf_r2;
    logic [7:0] lf_c1;
    logic [7:0] lf_r3;
    logic [7:0] lf_c3;
  } pcrb_pll_cfg_type;

  // ============================================================
  // nonvolatile loader states
  typedef enum logic [2:0] {
    LD_READ,
    LD_NEXT,
    LD_IDLE,
    LD_STPREP,
    LD_STORE
  } pcrb_ld_state_type;

endpackage

// [hw/pcrb_nv_loader.sv]
// walks the nonvolatile store: loads defaults at power-up, saves on commit
// assumes the store answers each access with nv_ack_i on the same clock
`include "pcrb_regs.svh"

module pcrb_nv_loader (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // commands
  input wire logic commit_i,
  // store side
  input wire logic nv_ack_i,
  input wire logic [7:0] nv_rdata_i,
  input wire logic [7:0] st_data_i,
  output logic nv_rd_o,
  output logic nv_wr_o,
  output logic [7:0] nv_addr_o,
  output logic [7:0] nv_wdata_o,
  // bank side
  output logic ld_we_o,
  output logic [7:0] ld_data_o,
  output logic busy_o,
  output logic load_done_o
);

  pcrb_pkg::pcrb_ld_state_type state_r, state_nxt;
  logic [7:0] idx_r, idx_nxt, data_r, data_nxt, wdata_r, wdata_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, we_r, we_nxt, busy_r, busy_nxt, done_r, done_nxt;

  // ============================================================
  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    data_nxt = data_r;
    wdata_nxt = wdata_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    we_nxt = 1'b0;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    case (state_r)
      pcrb_pkg::LD_READ: begin
        if (nv_ack_i) begin
          data_nxt = nv_rdata_i;
          we_nxt = 1'b1;
          rd_nxt = 1'b0;
          state_nxt = pcrb_pkg::LD_NEXT;
        end
      end
      pcrb_pkg::LD_NEXT: begin
        if (idx_r == `PCRB_LAST_INDEX) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = pcrb_pkg::LD_IDLE;
        end else begin
          idx_nxt = 8'(idx_r + 8'h01);
          rd_nxt = 1'b1;
          state_nxt = pcrb_pkg::LD_READ;
        end
      end
      pcrb_pkg::LD_IDLE: begin
        if (commit_i) begin
          idx_nxt = 8'h00;
          busy_nxt = 1'b1;
          state_nxt = pcrb_pkg::LD_STPREP;
        end
      end
      pcrb_pkg::LD_STPREP: begin
        wr_nxt = 1'b1;
        wdata_nxt = st_data_i;
        state_nxt = pcrb_pkg::LD_STORE;
      end
      pcrb_pkg::LD_STORE: begin
        if (nv_ack_i) begin
          wr_nxt = 1'b0;
          if (idx_r == `PCRB_LAST_INDEX) begin
            busy_nxt = 1'b0;
            state_nxt = pcrb_pkg::LD_IDLE;
          end else begin
            idx_nxt = 8'(idx_r + 8'h01);
            state_nxt = pcrb_pkg::LD_STPREP;
          end
        end
      end
      default: state_nxt = pcrb_pkg::LD_IDLE;
    endcase
  end

  // sequencer registers; reset starts the load at index zero
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= pcrb_pkg::LD_READ;
      idx_r <= 8'h00;
      data_r <= 8'h00;
      wdata_r <= 8'h00;
      rd_r <= 1'b1;
      wr_r <= 1'b0;
      we_r <= 1'b0;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      data_r <= data_nxt;
      wdata_r <= wdata_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      we_r <= we_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign nv_rd_o = rd_r;
  assign nv_wr_o = wr_r;
  assign nv_addr_o = idx_r;
  assign nv_wdata_o = wdata_r;
  assign ld_we_o = we_r;
  assign ld_data_o = data_r;
  assign busy_o = busy_r;
  assign load_done_o = done_r;

  // ============================================================
  // checks
  sequence s_nv_read_acked;
    rd_r && nv_ack_i;
  endsequence

  a_load_byte_written: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_nv_read_acked |=> ld_we_o && (ld_data_o == $past(nv_rdata_i)))
    else $error("acked store byte not written into bank");

  a_commit_starts_store: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state_r == pcrb_pkg::LD_IDLE) && commit_i |=> busy_o ##1 nv_wr_o && (nv_addr_o == 8'h00))
    else $error("commit did not start a store at index zero");

endmodule

// [hw/pcrb_bank.sv]
// pll configuration register bank: host byte port, nonvolatile defaults, decode
// assumes the host byte port and the store port run on core_clk_i
`include "pcrb_regs.svh"

module pcrb_bank (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // host register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_busy_o,
  // nonvolatile store port
  input wire logic nv_commit_i,
  input wire logic nv_ack_i,
  input wire logic [7:0] nv_rdata_i,
  output logic nv_rd_o,
  output logic nv_wr_o,
  output logic [7:0] nv_addr_o,
  output logic [7:0] nv_wdata_o,
  // pll configuration outputs
  output pcrb_pkg::pcrb_pll_cfg_type pll_cfg_o,
  output logic cfg_valid_o,
  output logic [1:0] doubler_factor_o,
  output logic [7:0] phase_comparator_mhz_o,
  output logic vco_recal_o
);

  localparam logic [`PCRB_ADDR_SPAN-1:0] IMPL = `PCRB_IMPL_MASK;

  logic [`PCRB_ADDR_SPAN-1:0][7:0] cfg_r, cfg_nxt;
  logic ld_we, ld_busy, ld_done;
  logic [7:0] ld_data, st_data;
  logic host_wr;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic recal_r, recal_nxt;
  pcrb_pkg::pcrb_pll_cfg_type cfg_out_r, cfg_out_nxt;
  logic valid_r, valid_nxt;
  logic [1:0] factor_r, factor_nxt;
  logic [7:0] pfd_r, pfd_nxt;

  // ============================================================
  // nonvolatile store sequencer
  pcrb_nv_loader u_loader (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .commit_i(nv_commit_i),
    .nv_ack_i(nv_ack_i),
    .nv_rdata_i(nv_rdata_i),
    .st_data_i(st_data),
    .nv_rd_o(nv_rd_o),
    .nv_wr_o(nv_wr_o),
    .nv_addr_o(nv_addr_o),
    .nv_wdata_o(nv_wdata_o),
    .ld_we_o(ld_we),
    .ld_data_o(ld_data),
    .busy_o(ld_busy),
    .load_done_o(ld_done)
  );

  // host writes are ignored while the store is being walked
  // so a load is never half overwritten and a save sends one snapshot
  assign host_wr = reg_wr_i && !ld_busy;

  // bank byte handed to the store
  always_comb begin
    st_data = 8'h00;
    if (nv_addr_o < 8'(`PCRB_ADDR_SPAN)) begin
      st_data = cfg_r[nv_addr_o[5:0]];
    end
  end

  // ============================================================
  // register array, one entry per address
  generate
    for (genvar i = 0; i < `PCRB_ADDR_SPAN; i++) begin : g_entry
      if (IMPL[i]) begin : g_impl
        // store load has the bank while busy
        assign cfg_nxt[i] = (ld_we && (nv_addr_o == 8'(i))) ? ld_data :
                            (host_wr && (reg_addr_i == 8'(i))) ? reg_wdata_i : cfg_r[i];
      end else begin : g_none
        assign cfg_nxt[i] = `PCRB_RESET_VALUE;
      end
    end
  endgenerate

  // register array storage
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= {`PCRB_ADDR_SPAN{`PCRB_RESET_VALUE}};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ============================================================
  // host read port and calibration request
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i < 8'(`PCRB_ADDR_SPAN)) begin
        rdata_nxt = cfg_r[reg_addr_i[5:0]];
      end else if (reg_addr_i == `PCRB_OFS_VCO_CAL) begin
        rdata_nxt = 8'h00; // request bit clears itself
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    // calibration on request or after load
    recal_nxt = ld_done ||
                (host_wr && (reg_addr_i == `PCRB_OFS_VCO_CAL) &&
                 reg_wdata_i[`PCRB_VCO_CAL_BIT]);
  end

  // read port and calibration registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      recal_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      recal_r <= recal_nxt;
    end
  end

  // ============================================================
  // field decode toward the pll
  always_comb begin
    cfg_out_nxt.load_cap_a = cfg_r[`PCRB_OFS_LOAD_CAP_A];
    cfg_out_nxt.load_cap_b = cfg_r[`PCRB_OFS_LOAD_CAP_B];
    cfg_out_nxt.fb_int = {cfg_r[`PCRB_OFS_FB_DIV_0][3:0], cfg_r[`PCRB_OFS_FB_DIV_1]};
    cfg_out_nxt.fb_num = {cfg_r[`PCRB_OFS_FB_DIV_2][5:0], cfg_r[`PCRB_OFS_FB_DIV_3],
                          cfg_r[`PCRB_OFS_FB_DIV_4]};
    cfg_out_nxt.feedback_denominator = {cfg_r[`PCRB_OFS_FB_DIV_5][5:0],
                                        cfg_r[`PCRB_OFS_FB_DIV_6],
                                        cfg_r[`PCRB_OFS_FB_DIV_7]};
    cfg_out_nxt.output_divide_value = {cfg_r[`PCRB_OFS_OUTPUT_DIVIDE_VALUE_HI][0],
                                       cfg_r[`PCRB_OFS_OUTPUT_DIVIDE_VALUE_LO]};
    cfg_out_nxt.dsm_order = cfg_r[`PCRB_OFS_MOD_DITHER][1:0];
    cfg_out_nxt.dither = cfg_r[`PCRB_OFS_MOD_DITHER][3:2];
    cfg_out_nxt.doubler_en = cfg_r[`PCRB_OFS_DOUBLER_PUMP][`PCRB_DOUBLER_BIT];
    cfg_out_nxt.pump_sel = cfg_r[`PCRB_OFS_DOUBLER_PUMP][3:0];
    cfg_out_nxt.phase_shift = cfg_r[`PCRB_OFS_PHASE_FILTER][6:4];
    cfg_out_nxt.filter_en = cfg_r[`PCRB_OFS_PHASE_FILTER][`PCRB_FILTER_EN_BIT];
    cfg_out_nxt.lf_r2 = cfg_r[`PCRB_OFS_LF_R2];
    cfg_out_nxt.lf_c1 = cfg_r[`PCRB_OFS_LF_C1];
    cfg_out_nxt.lf_r3 = cfg_r[`PCRB_OFS_LF_R3];
    cfg_out_nxt.lf_c3 = cfg_r[`PCRB_OFS_LF_C3];
    factor_nxt = cfg_out_nxt.doubler_en ? `PCRB_FACTOR_ON : `PCRB_FACTOR_OFF;
    pfd_nxt = cfg_out_nxt.doubler_en ? `PCRB_PFD_MHZ_ON : `PCRB_PFD_MHZ_OFF;
    valid_nxt = (cfg_out_nxt.fb_int >= `PCRB_INT_MIN) &&
                (cfg_out_nxt.feedback_denominator >= `PCRB_DEN_MIN) &&
                (cfg_out_nxt.output_divide_value >= `PCRB_OUTPUT_DIVIDE_VALUE_MIN);
  end

  // decoded output registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_out_r <= '0;
      valid_r <= 1'b0;
      factor_r <= `PCRB_FACTOR_OFF;
      pfd_r <= `PCRB_PFD_MHZ_OFF;
    end else begin
      cfg_out_r <= cfg_out_nxt;
      valid_r <= valid_nxt;
      factor_r <= factor_nxt;
      pfd_r <= pfd_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign reg_busy_o = ld_busy;
  assign pll_cfg_o = cfg_out_r;
  assign cfg_valid_o = valid_r;
  assign doubler_factor_o = factor_r;
  assign phase_comparator_mhz_o = pfd_r;
  assign vco_recal_o = recal_r;

  // ============================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_host_write_ok;
    host_wr && (reg_addr_i < 8'(`PCRB_ADDR_SPAN)) && IMPL[reg_addr_i[5:0]];
  endsequence

  sequence s_read_back(logic [7:0] d);
    reg_rvalid_o && (reg_rdata_o == d);
  endsequence

  a_write_read_back: assert property (
    s_host_write_ok ##1 (reg_rd_i && !reg_wr_i && !ld_we && (reg_addr_i == $past(reg_addr_i)))
    |=> s_read_back($past(reg_wdata_i, 2)))
    else $error("written byte not read back");

  a_doubler_factor: assert property (
    doubler_factor_o == (pll_cfg_o.doubler_en ? `PCRB_FACTOR_ON : `PCRB_FACTOR_OFF))
    else $error("doubler factor disagrees with enable bit");

  a_doubler_bit_path: assert property (
    host_wr && (reg_addr_i == `PCRB_OFS_DOUBLER_PUMP) && !ld_we
    |=> ##1 pll_cfg_o.doubler_en == $past(reg_wdata_i[`PCRB_DOUBLER_BIT], 2))
    else $error("doubler enable did not follow its register bit");

  a_comparator_rate: assert property (
    phase_comparator_mhz_o == (pll_cfg_o.doubler_en ? `PCRB_PFD_MHZ_ON : `PCRB_PFD_MHZ_OFF))
    else $error("comparator rate disagrees with doubler");

  a_int_nonzero: assert property (
    (pll_cfg_o.fb_int == 12'h000) |-> !cfg_valid_o)
    else $error("zero integer part reported valid");

  a_den_nonzero: assert property (
    (pll_cfg_o.feedback_denominator == 22'h000000) |-> !cfg_valid_o)
    else $error("zero denominator reported valid");

  a_output_divide_value_range: assert property (
    cfg_valid_o |-> (pll_cfg_o.output_divide_value >= `PCRB_OUTPUT_DIVIDE_VALUE_MIN))
    else $error("output divide below five reported valid");

  a_recal_request: assert property (
    host_wr && (reg_addr_i == `PCRB_OFS_VCO_CAL) && reg_wdata_i[`PCRB_VCO_CAL_BIT]
    |=> vco_recal_o)
    else $error("calibration request not issued");

  a_recal_after_load: assert property (
    ld_done |=> vco_recal_o ##1 !reg_busy_o)
    else $error("calibration not issued after default load");

  a_unbacked_zero: assert property (
    reg_rd_i && !((reg_addr_i < 8'(`PCRB_ADDR_SPAN)) && IMPL[reg_addr_i[5:0]])
    |=> reg_rvalid_o && (reg_rdata_o == 8'h00))
    else $error("unbacked address read nonzero");

  a_contents_persist: assert property (
    !ld_we && !host_wr |=> $stable(cfg_r))
    else $error("register contents changed without a write");

  a_busy_refuses_host: assert property (
    reg_busy_o && reg_wr_i && !ld_we |=> $stable(cfg_r))
    else $error("host write taken during store walk");

  // ============================================================
  // decoded field paths: a write reaches the array at the next edge and
  // the output registers one edge later, so each path is checked two edges on
  sequence s_cfg_write(logic [7:0] a);
    host_wr && (reg_addr_i == a);
  endsequence

  a_load_cap_path: assert property (
    s_cfg_write(`PCRB_OFS_LOAD_CAP_A) |=> ##1 pll_cfg_o.load_cap_a == $past(reg_wdata_i, 2))
    else $error("load capacitance did not follow its register");

  a_int_low_path: assert property (
    s_cfg_write(`PCRB_OFS_FB_DIV_1) |=> ##1 pll_cfg_o.fb_int[7:0] == $past(reg_wdata_i, 2))
    else $error("integer low byte did not follow its register");

  a_order_path: assert property (
    s_cfg_write(`PCRB_OFS_MOD_DITHER) |=> ##1 pll_cfg_o.dsm_order == $past(reg_wdata_i[1:0], 2))
    else $error("modulator order did not follow its register");

  a_pump_path: assert property (
    s_cfg_write(`PCRB_OFS_DOUBLER_PUMP) |=> ##1 pll_cfg_o.pump_sel == $past(reg_wdata_i[3:0], 2))
    else $error("pump slices did not follow their register");

  a_filter_r3_path: assert property (
    s_cfg_write(`PCRB_OFS_LF_R3) |=> ##1 pll_cfg_o.lf_r3 == $past(reg_wdata_i, 2))
    else $error("third filter component did not follow its register");

  // ============================================================
  // array, read port and store path; a host write never meets a load
  // write, since the load only writes while busy refuses the host
  a_host_write_lands: assert property (
    s_host_write_ok |=> cfg_r[$past(reg_addr_i[5:0])] == $past(reg_wdata_i))
    else $error("host write did not land in its entry");

  a_read_valid_pulse: assert property (
    reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid does not follow the read strobe");

  // the flag only reports range, it never blocks the stored values
  a_valid_when_legal: assert property (
    (pll_cfg_o.fb_int != 12'h000) && (pll_cfg_o.feedback_denominator != 22'h000000) &&
    (pll_cfg_o.output_divide_value >= `PCRB_OUTPUT_DIVIDE_VALUE_MIN) |-> cfg_valid_o)
    else $error("legal divider settings reported invalid");

  // the bank stays frozen during a save, so the byte sent must match its entry
  a_store_data_source: assert property (
    $rose(nv_wr_o) |-> nv_wdata_o == cfg_r[nv_addr_o[5:0]])
    else $error("saved byte differs from its bank entry");

endmodule

// [tb/pcrb_nv_store.sv]
// nonvolatile store model facing the store port of the register bank
// assumes each request is held until the one-cycle ack; lat_i sets the answer delay
module pcrb_nv_store #(
  parameter logic [7:0] FILL = 8'h3C
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // access side
  input wire logic nv_rd_i,
  input wire logic nv_wr_i,
  input wire logic [7:0] nv_addr_i,
  input wire logic [7:0] nv_wdata_i,
  input wire logic [3:0] lat_i,
  output logic nv_ack_o,
  output logic [7:0] nv_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:39];
  logic [3:0] wait_r;

  // ============================================================
  // contents
  // factory defaults
  initial begin
    for (int i = 0; i < 40; i++) begin
      mem[i] = FILL ^ 8'(i);
    end
  end

  // ============================================================
  // access engine
  // serve loads and saves
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_ack_o <= 1'b0;
      wait_r <= 4'h0;
      nv_rdata_o <= 8'hA5;
    end else if (!nv_ack_o && (nv_rd_i || nv_wr_i) && wait_r >= lat_i) begin
      nv_ack_o <= 1'b1;
      wait_r <= 4'h0;
      nv_rdata_o <= ~nv_rdata_o;
      if (nv_addr_i < 8'h28 && nv_rd_i) begin
        nv_rdata_o <= mem[nv_addr_i];
      end
      if (nv_addr_i < 8'h28 && nv_wr_i) begin
        mem[nv_addr_i] <= nv_wdata_i;
      end
    end else begin
      // data outside an ack keeps toggling so nothing stale looks valid
      nv_ack_o <= 1'b0;
      nv_rdata_o <= ~nv_rdata_o;
      if (nv_rd_i || nv_wr_i) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

// [tb/test_pcrb_bank.sv]
// self-checking bench for the pll configuration register bank
// assumes the store model on the store port; inputs move on falling edges
module test_pcrb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FILL = 8'h3C;
  localparam logic [15:0] DEC [17] = '{16'h19FF, 16'h1AFF, 16'h1BFF, 16'h1CFF, 16'h1DFF,
    16'h1EC0, 16'h1F00, 16'h2000, 16'h1601, 16'h17FF, 16'h2107, 16'h222A, 16'h2324,
    16'h2411, 16'h2522, 16'h2633, 16'h2744};
  localparam logic [15:0] CFG [14] = '{16'h1900, 16'h1A64, 16'h1B00, 16'h1C00, 16'h1D00,
    16'h1E00, 16'h1F00, 16'h2001, 16'h1600, 16'h1720, 16'h2100, 16'h2208, 16'h2300, 16'h2600};
  logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i, nv_commit_i, nv_ack_i;
  logic reg_rvalid_o, reg_busy_o, nv_rd_o, nv_wr_o, cfg_valid_o, vco_recal_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, nv_rdata_i, nv_addr_o, nv_wdata_o;
  logic [7:0] phase_comparator_mhz_o;
  logic [1:0] doubler_factor_o;
  logic [3:0] lat;
  pcrb_pkg::pcrb_pll_cfg_type pll_cfg_o;
  logic [7:0] shadow [0:39];
  int num_errors = 0;
  int checked = 0;

  // ============================================================
  // block and partner
  pcrb_bank dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_busy_o(reg_busy_o),
    .nv_commit_i(nv_commit_i), .nv_ack_i(nv_ack_i), .nv_rdata_i(nv_rdata_i),
    .nv_rd_o(nv_rd_o), .nv_wr_o(nv_wr_o), .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o),
    .pll_cfg_o(pll_cfg_o), .cfg_valid_o(cfg_valid_o), .doubler_factor_o(doubler_factor_o),
    .phase_comparator_mhz_o(phase_comparator_mhz_o), .vco_recal_o(vco_recal_o));
  pcrb_nv_store #(.FILL(FILL)) store_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .nv_rd_i(nv_rd_o), .nv_wr_i(nv_wr_o), .nv_addr_i(nv_addr_o), .nv_wdata_i(nv_wdata_o),
    .lat_i(lat), .nv_ack_o(nv_ack_i), .nv_rdata_o(nv_rdata_i));

  // clock at 100 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ============================================================
  // helpers
  function automatic logic backed(input logic [7:0] a);
    return a == 8'h10 || a == 8'h11 || a == 8'h16 || a == 8'h17 || (a >= 8'h19 && a <= 8'h27);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // single byte write; the shadow follows only writes the bank may take
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic bz;
    @(negedge core_clk_i);
    bz = reg_busy_o;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    if (bz === 1'b0 && backed(a)) begin
      shadow[a[5:0]] = d;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk("rvalid", 1, reg_rvalid_o);
    chk("rdata", exp, reg_rdata_o);
    @(negedge core_clk_i);
    chk("rvalid_end", 0, reg_rvalid_o);
  endtask

  task automatic rd_all();
    for (int a = 0; a < 40; a++) begin
      rd(8'(a), shadow[a]);
    end
    rd(8'h48, 8'h00);
    rd(8'h80, 8'h00);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (reg_busy_o !== 1'b0 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 2000) begin
      num_errors++;
      $display("BAD busy expected 0 seen %b", reg_busy_o);
      results();
    end
  endtask

  // ============================================================
  // scenarios
  // power-up load with a slow store, then the calibration pulse
  task automatic t_load();
    logic seen;
    wait_idle();
    @(negedge core_clk_i);
    seen = vco_recal_o;
    @(negedge core_clk_i);
    seen = seen | vco_recal_o;
    chk("recal_powerup", 1, seen);
    rd_all();
  endtask

  task automatic t_rw();
    for (int a = 0; a < 40; a++) begin
      wr(8'(a), 8'h81 + 8'(a));
    end
    rd_all();
    // write then read the same entry on the very next edge
    @(negedge core_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = 8'h25;
    reg_wdata_i = 8'h5C;
    shadow[37] = 8'h5C;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk("rdata_b2b", 32'h5C, reg_rdata_o);
  endtask

  task automatic t_decode();
    foreach (DEC[i]) wr(DEC[i][15:8], DEC[i][7:0]);
    @(negedge core_clk_i);
    chk("fb_int", 32'hFFF, pll_cfg_o.fb_int);
    chk("fb_num", 32'h3FFFFF, pll_cfg_o.fb_num);
    chk("den", 0, pll_cfg_o.feedback_denominator);
    chk("valid_den0", 0, cfg_valid_o);
    chk("output_divide_value", 32'h1FF, pll_cfg_o.output_divide_value);
    chk("dsm", 3, pll_cfg_o.dsm_order);
    chk("dither", 1, pll_cfg_o.dither);
    chk("doubler", 1, pll_cfg_o.doubler_en);
    chk("factor", 2, doubler_factor_o);
    chk("mhz", 32'h64, phase_comparator_mhz_o);
    chk("pump", 32'hA, pll_cfg_o.pump_sel);
    chk("phase", 2, pll_cfg_o.phase_shift);
    chk("filter", 1, pll_cfg_o.filter_en);
    chk("lf", 32'h11223344, {pll_cfg_o.lf_r2, pll_cfg_o.lf_c1, pll_cfg_o.lf_r3,
      pll_cfg_o.lf_c3});
    wr(8'h10, 8'h5A);
    wr(8'h11, 8'hA5);
    wr(8'h20, 8'h01);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h05);
    wr(8'h22, 8'h05);
    @(negedge core_clk_i);
    chk("cap", 32'h5AA5, {pll_cfg_o.load_cap_a, pll_cfg_o.load_cap_b});
    chk("valid_min", 1, cfg_valid_o);
    chk("factor_off", 1, doubler_factor_o);
    chk("mhz_off", 32'h32, phase_comparator_mhz_o);
    chk("pump_b", 5, pll_cfg_o.pump_sel);
    wr(8'h17, 8'h04);
    @(negedge core_clk_i);
    chk("valid_div4", 0, cfg_valid_o);
    // integer mode with the doubler on keeps the upper filter parts
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h28);
    wr(8'h23, 8'h04);
    wr(8'h27, 8'h55);
    @(negedge core_clk_i);
    chk("int_dbl", 3, {pll_cfg_o.dsm_order, pll_cfg_o.doubler_en, pll_cfg_o.filter_en});
    chk("lf_c3", 32'h55, pll_cfg_o.lf_c3);
  endtask

  task automatic t_recal();
    for (int i = 0; i < 2; i++) begin
      wr(8'h48, 8'(2 * i));
      chk("recal", i, vco_recal_o);
      @(negedge core_clk_i);
      chk("recal_end", 0, vco_recal_o);
    end
    rd(8'h48, 8'h00);
  endtask

  // integer mode at 5 GHz, saved with a prompt store; a write while busy is dropped
  task automatic t_save();
    foreach (CFG[i]) wr(CFG[i][15:8], CFG[i][7:0]);
    wr(8'h48, 8'h02);
    lat = 4'h0;
    @(negedge core_clk_i);
    nv_commit_i = 1'b1;
    @(negedge core_clk_i);
    nv_commit_i = 1'b0;
    chk("busy_save", 1, reg_busy_o);
    wr(8'h24, 8'hEE);
    wait_idle();
    for (int i = 0; i < 40; i++) begin
      chk("stored", shadow[i], store_u.mem[i]);
    end
    rd(8'h24, shadow[36]);
  endtask

  task automatic t_reload();
    @(negedge core_clk_i);
    nrst_i = 1'b0;
    lat = 4'h3;
    @(negedge core_clk_i);
    chk("busy_rst", 1, reg_busy_o);
    chk("factor_rst", 1, doubler_factor_o);
    chk("mhz_rst", 32'h32, phase_comparator_mhz_o);
    nrst_i = 1'b1;
    wr(8'h24, 8'h77);
    wait_idle();
    rd_all();
    chk("fb_int_load", 32'h64, pll_cfg_o.fb_int);
    chk("valid_load", 1, cfg_valid_o);
  endtask

  // ============================================================
  // main sequence
  initial begin
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    nv_commit_i = 1'b0;
    lat = 4'h2;
    for (int i = 0; i < 40; i++) begin
      shadow[i] = backed(8'(i)) ? (FILL ^ 8'(i)) : 8'h00;
    end
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_load();
    t_rw();
    t_decode();
    t_recal();
    t_save();
    t_reload();
    results();
  end
endmodule
